// >>> hw/phwp_top.sv
// Notes on behaviour
// [R01] Handshake: drop control, await peripheral low, sample
// [R02] After sampling, raise control to show busy
// [R03] Zero delay: wait forever for peripheral high
// [R04] Nonzero delay: timeout restarts next byte cycle
// [R05] Peripheral drops line with data, raises to ack
// [R06] Strobe delay count 0..255, control line only
// [R07] Strobe out: control high, drive byte, inverted optionally
// [R08] Strobe out: control low exactly delay, repeat; code holds it low dly units plus one cycle
// [R09] Strobe in: high, low, wait delay, sample, repeat
// [R10] Wake only when armed, wake high, masked line high
// [R11] Mask rewritable alone, target id kept
// [R12] Disarm clears mask and target id
// [R13] Wake interrupt is level, reasserts while condition holds
// [R14] Zero mask blocks wake; new mask reevaluates immediately
// [R15] Mask or target above 999 rejected with error
// [R16] One delay unit is 0.75 ms
// [R17] Bit n maps to data line n
// [R18] Invert complements every output bit; disable restores
// [R19] Control, wake and data inputs synchronised first
`default_nettype none
module phwp_top
  import phwp_pkg::*;
(
  input wire logic pclk, // Clock, 100 MHz
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [7:0] input_data_lines, // Data from peripheral
  input wire logic peripheral_control_line, // Peripheral control pin
  input wire logic wake_line, // External wake pin
  output logic [7:0] output_data_lines, // Data to peripheral
  output logic module_control_line, // Module control pin
  output logic wake_irq, // Wake interrupt, level
  output logic irq // Event interrupt, level
);
  typedef struct packed {
    phwp_state_type st;
    logic [1:0] mode;
    logic inv;
    logic txv;
    logic [7:0] dly;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic arm;
    logic [7:0] mask;
    logic [9:0] tgt;
    logic [PHWP_NEV-1:0] stat;
    logic [PHWP_NEV-1:0] ien;
    logic [7:0] units;
    logic [31:0] cyc;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic ctl;
    logic [7:0] dout;
    logic wirq;
    logic irq;
  } phwp_st_type;
  phwp_st_type r_q, r_d;
  phwp_pins_type pin_s;
  logic wr_acc;
  logic rd_acc;
  logic unit_tick;
  logic dly_done;
  logic wake_cond;
  logic [PHWP_NEV-1:0] ev;
  // Pins pass two flops before anything looks at them
  phwp_sync #(.W(10)) u_sync ( // [R19]
    .pclk(pclk),
    .presetn(presetn),
    .d({input_data_lines, peripheral_control_line, wake_line}),
    .q(pin_s)
  );
  // Access phase of APB; registered pready answers one cycle into it, one wait state
  assign wr_acc = psel && penable && pwrite && !r_q.ready;
  assign rd_acc = psel && penable && !pwrite && !r_q.ready;
  // Unit divider tick and delay completion
  assign unit_tick = (r_q.cyc == 32'(PHWP_UNIT_CYC - 1)); // [R16]
  assign dly_done = (r_q.units >= r_q.dly);
  // Wake condition is combinational on synced pins
  assign wake_cond = r_q.arm && pin_s.wake && |(pin_s.din & r_q.mask); // [R10] [R14] [R17]
  always_comb
  begin
    r_d = r_q;
    ev = '0;
    r_d.ready = 1'b0;
    r_d.err = 1'b0;
    // Delay counter: count units while in a timed state
    if (r_q.st == S_ACK || r_q.st == S_LOW)
    begin
      if (unit_tick)
      begin
        r_d.cyc = '0;
        if (!dly_done)
          r_d.units = r_q.units + 8'h01;
      end
      else
        r_d.cyc = r_q.cyc + 32'h0000_0001;
    end
    // Port sequencer
    case (r_q.st)
      S_IDLE:
      begin
        r_d.ctl = 1'b1;
        if (r_q.mode == PHWP_M_HSIN)
        begin
          r_d.ctl = 1'b0; // [R01]
          r_d.st = S_READY;
        end
        else if (r_q.mode == PHWP_M_STIN)
          r_d.st = S_HIGH;
        else if (r_q.mode == PHWP_M_STOUT && r_q.txv)
        begin
          r_d.dout = r_q.inv ? ~r_q.txd : r_q.txd; // [R07] [R18] [R17]
          r_d.txv = 1'b0;
          r_d.st = S_HIGH;
        end
      end
      S_READY:
      begin
        // Wait for peripheral to show data, then sample and go busy
        if (!pin_s.ctl) // [R01] [R05]
        begin
          r_d.rxd = pin_s.din;
          r_d.ctl = 1'b1; // [R02]
          ev[PHWP_EV_RX] = 1'b1;
          r_d.units = '0;
          r_d.cyc = '0;
          r_d.st = S_ACK;
        end
      end
      S_ACK:
      begin
        // Ack from peripheral, or timeout when delay is nonzero
        if (pin_s.ctl) // [R03] [R05]
          r_d.st = S_IDLE;
        else if (r_q.dly != 8'h00 && dly_done) // [R04]
        begin
          ev[PHWP_EV_TMO] = 1'b1;
          r_d.st = S_IDLE;
        end
      end
      S_HIGH:
      begin
        // One cycle high, then low for the delay
        r_d.ctl = 1'b1; // [R07] [R09]
        r_d.ctl = 1'b0;
        r_d.units = '0;
        r_d.cyc = '0;
        r_d.st = S_LOW;
      end
      S_LOW:
      begin
        // Low held for dly units plus one cycle; dly 0 gives one cycle
        if (dly_done) // [R06] [R08] [R09]
        begin
          r_d.ctl = 1'b1;
          if (r_q.mode == PHWP_M_STIN)
          begin
            r_d.rxd = pin_s.din;
            ev[PHWP_EV_RX] = 1'b1;
          end
          else
            ev[PHWP_EV_TX] = 1'b1;
          r_d.st = S_DONE;
        end
      end
      S_DONE:
        r_d.st = S_IDLE;
      default:
        r_d.st = S_IDLE;
    endcase
    // Register writes
    if (wr_acc)
    begin
      r_d.ready = 1'b1;
      case (paddr)
        PHWP_CTRL_OFF:
        begin
          r_d.mode = pwdata[PHWP_MODE_LSB +: 2];
          r_d.inv = pwdata[PHWP_INV_BIT]; // [R18]
          r_d.dly = pwdata[PHWP_DLY_LSB +: 8]; // [R06]
          if (pwdata[PHWP_MODE_LSB +: 2] != r_q.mode)
            r_d.st = S_IDLE;
        end
        PHWP_TXD_OFF:
        begin
          r_d.txd = pwdata[7:0];
          r_d.txv = 1'b1;
        end
        PHWP_WAKE_OFF:
        begin
          if (!pwdata[PHWP_ARM_BIT])
          begin
            r_d.arm = 1'b0; // [R12]
            r_d.mask = '0;
            r_d.tgt = '0;
          end
          else if (pwdata[9:0] > PHWP_PARAM_MAX ||
                   pwdata[PHWP_TGT_LSB +: 10] > PHWP_PARAM_MAX) // [R15]
          begin
            r_d.err = 1'b1;
            ev[PHWP_EV_ERR] = 1'b1;
          end
          else
          begin
            r_d.arm = 1'b1;
            r_d.mask = pwdata[7:0];
            r_d.tgt = pwdata[PHWP_TGT_LSB +: 10];
          end
        end
        PHWP_MASKW_OFF:
        begin
          if (pwdata[9:0] > PHWP_PARAM_MAX) // [R15]
          begin
            r_d.err = 1'b1;
            ev[PHWP_EV_ERR] = 1'b1;
          end
          else
            r_d.mask = pwdata[7:0]; // [R11] [R14]
        end
        PHWP_STAT_OFF:
          r_d.stat = r_q.stat & ~pwdata[PHWP_NEV-1:0];
        PHWP_IEN_OFF:
          r_d.ien = pwdata[PHWP_NEV-1:0];
        default:
          r_d.err = 1'b1;
      endcase
    end
    // Register reads
    if (rd_acc)
    begin
      r_d.ready = 1'b1;
      r_d.rdata = '0;
      case (paddr)
        PHWP_CTRL_OFF:
          r_d.rdata = {16'h0000, r_q.dly, 4'h0, r_q.txv, r_q.inv, r_q.mode};
        PHWP_TXD_OFF:
          r_d.rdata = {24'h0000_00, r_q.txd};
        PHWP_RXD_OFF:
          r_d.rdata = {24'h0000_00, r_q.rxd};
        PHWP_WAKE_OFF:
          r_d.rdata = {r_q.arm, 5'h00, r_q.tgt, 8'h00, r_q.mask};
        PHWP_MASKW_OFF:
          r_d.rdata = {24'h0000_00, r_q.mask};
        PHWP_STAT_OFF:
          r_d.rdata = {27'h000_0000, r_q.stat};
        PHWP_IEN_OFF:
          r_d.rdata = {27'h000_0000, r_q.ien};
        PHWP_LINE_OFF:
          r_d.rdata = {16'h0000, r_q.st == S_IDLE, 5'h00, pin_s.wake, pin_s.ctl,
                       pin_s.din};
        default:
          r_d.err = 1'b1;
      endcase
    end
    // Sticky status: a set in the clearing cycle wins
    ev[PHWP_EV_WAKE] = wake_cond;
    r_d.stat = r_d.stat | ev;
    // Level wake follows the live condition
    r_d.wirq = wake_cond; // [R13] [R14]
    r_d.irq = |(r_d.stat & r_q.ien);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= '0;
      r_q.st <= S_IDLE;
      r_q.ctl <= 1'b1;
    end
    else
      r_q <= r_d;
  end
  // Outputs straight from flops
  assign prdata = r_q.rdata;
  assign pready = r_q.ready;
  assign pslverr = r_q.err;
  assign output_data_lines = r_q.dout;
  assign module_control_line = r_q.ctl;
  assign wake_irq = r_q.wirq;
  assign irq = r_q.irq;
  // Assertions
  hs_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
    (r_q.st == S_READY && !pin_s.ctl) |=> (module_control_line && r_q.st == S_ACK))
    else $error("control not raised after sample");
  hs_ready_a: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    (r_q.st == S_READY) |-> !module_control_line)
    else $error("control not low while ready");
  hs_nowait_a: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
    (r_q.st == S_ACK && r_q.dly == 8'h00 && !pin_s.ctl && !wr_acc) |=> r_q.st == S_ACK)
    else $error("left ack wait without peripheral high");
  hs_timeout_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
    (r_q.st == S_ACK && r_q.dly != 8'h00 && dly_done) |=> r_q.st == S_IDLE)
    else $error("timeout not honoured");
  st_low_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    (r_q.st == S_LOW && !dly_done) |-> !module_control_line)
    else $error("strobe low not held");
  st_inv_a: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    (r_q.st == S_IDLE && r_q.mode == PHWP_M_STOUT && r_q.txv && !wr_acc)
    |=> output_data_lines == (r_q.inv ? ~$past(r_q.txd) : $past(r_q.txd)))
    else $error("output polarity wrong");
  wake_level_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    wake_irq == $past(wake_cond))
    else $error("wake irq mismatch");
  wake_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    (r_q.mask == 8'h00) |=> !wake_irq)
    else $error("zero mask woke");
  disarm_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    (wr_acc && paddr == PHWP_WAKE_OFF && !pwdata[PHWP_ARM_BIT])
    |=> (r_q.mask == 8'h00 && r_q.tgt == 10'h000 && !r_q.arm))
    else $error("disarm kept state");
  mask_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    (wr_acc && paddr == PHWP_MASKW_OFF) |=> $stable(r_q.tgt))
    else $error("mask write changed target");
  param_err_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    (wr_acc && paddr == PHWP_MASKW_OFF && pwdata[9:0] > PHWP_PARAM_MAX)
    |=> (pslverr && $stable(r_q.mask)))
    else $error("oversize mask accepted");
  // Strobe phases: control high before the low, released once the delay ends
  st_high_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    (r_q.st == S_HIGH) |-> module_control_line)
    else $error("strobe high phase missing");
  st_release_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    (r_q.st == S_LOW && dly_done) |=> module_control_line)
    else $error("strobe low overran delay");
  st_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    (r_q.st == S_LOW && r_q.mode == PHWP_M_STIN && dly_done)
    |=> r_q.rxd == $past(pin_s.din))
    else $error("strobe input not sampled");
  cv_hs: cover property (@(posedge pclk) r_q.st == S_ACK ##1 r_q.st == S_IDLE);
  cv_tmo: cover property (@(posedge pclk) ev[PHWP_EV_TMO]);
  cv_stb: cover property (@(posedge pclk) ev[PHWP_EV_TX]);
  cv_wake: cover property (@(posedge pclk) wake_irq);
  // Strobe input sample point reached
  cv_stin: cover property (@(posedge pclk) ev[PHWP_EV_RX] && r_q.st == S_LOW);
endmodule
`default_nettype wire

// >>> hw/phwp_pkg.sv
`default_nettype none
package phwp_pkg;
  // APB register byte offsets
  localparam logic [7:0] PHWP_CTRL_OFF = 8'h00; // Mode, invert, delay count
  localparam logic [7:0] PHWP_TXD_OFF = 8'h04;  // Output byte
  localparam logic [7:0] PHWP_RXD_OFF = 8'h08;  // Last input byte
  localparam logic [7:0] PHWP_WAKE_OFF = 8'h0C; // Wake arm, mask, target id
  localparam logic [7:0] PHWP_MASKW_OFF = 8'h10; // Mask-only rewrite
  localparam logic [7:0] PHWP_STAT_OFF = 8'h14; // Sticky event status
  localparam logic [7:0] PHWP_IEN_OFF = 8'h18;  // Event mask
  localparam logic [7:0] PHWP_LINE_OFF = 8'h1C; // Live line view
  // Control field positions
  localparam int PHWP_MODE_LSB = 0;  // 2 bits
  localparam int PHWP_INV_BIT = 2;
  localparam int PHWP_TXV_BIT = 3;   // Output byte pending
  localparam int PHWP_DLY_LSB = 8;   // 8 bits
  // Wake register fields
  localparam int PHWP_ARM_BIT = 31;
  localparam int PHWP_TGT_LSB = 16;  // 10 bits
  // Parameter limit for mask and target
  localparam logic [9:0] PHWP_PARAM_MAX = 10'h3E7;
  // Status bits
  localparam int PHWP_EV_RX = 0;
  localparam int PHWP_EV_TX = 1;
  localparam int PHWP_EV_TMO = 2;
  localparam int PHWP_EV_ERR = 3;
  localparam int PHWP_EV_WAKE = 4;
  localparam int PHWP_NEV = 5;
  // Delay unit of 0.75 ms in ns and cycles
  localparam longint PHWP_UNIT_NS = 750000;
  localparam longint PHWP_CLK_NS = 10;
  localparam int PHWP_UNIT_CYC = int'(PHWP_UNIT_NS / PHWP_CLK_NS);
  localparam logic [1:0] PHWP_M_IDLE = 2'h0;
  localparam logic [1:0] PHWP_M_HSIN = 2'h1;
  localparam logic [1:0] PHWP_M_STIN = 2'h2;
  localparam logic [1:0] PHWP_M_STOUT = 2'h3;
  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_READY = 6'b00_0010,
    S_ACK = 6'b00_0100,
    S_HIGH = 6'b00_1000,
    S_LOW = 6'b01_0000,
    S_DONE = 6'b10_0000
  } phwp_state_type;
  typedef struct packed {
    logic [7:0] din;
    logic ctl;
    logic wake;
  } phwp_pins_type;
endpackage
`default_nettype wire

// >>> hw/phwp_sync.sv
`default_nettype none
module phwp_sync
  import phwp_pkg::*;
#(
  parameter int W = 10
)(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [W-1:0] d, // Raw pin level
  output logic [W-1:0] q // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } phwp_sy_type;
  phwp_sy_type st_q, st_d;
  // Two-stage pipe; first stage is read only by the second
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign q = st_q.s2;
endmodule
`default_nettype wire

// >>> test/phwp_peripheral.sv
`default_nettype none
module phwp_peripheral
(
  input wire logic pclk, // Clock
  input wire logic active, // Run interlocked transfers
  input wire logic stall, // Slow peripheral, keeps control low
  input wire logic [7:0] byte_in, // Byte to offer
  input wire logic module_control_line, // Module readiness
  output logic [7:0] input_data_lines, // Data pins
  output logic peripheral_control_line // Control pin, pulled up
);
  timeunit 1ns;
  timeprecision 1ps;
  logic presenting_q; // Byte currently offered

  // Offer while module is ready, withdraw once it shows busy and stall is low
  always_ff @(posedge pclk)
  begin
    if (!active)
      presenting_q <= 1'b0;
    else if (!module_control_line)
      presenting_q <= 1'b1;
    else if (!stall)
      presenting_q <= 1'b0;
  end

  // Data set up before control falls; stale lines show the inverse
  assign input_data_lines = (!active || presenting_q || !module_control_line) ?
                            byte_in : ~byte_in;
  // Pull-up holds the line high when not driven low
  assign peripheral_control_line = !(active && presenting_q);
endmodule
`default_nettype wire

// >>> test/parallel_handshake_wake_port_bench.sv
`default_nettype none
module parallel_handshake_wake_port_bench
  import phwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic err;
    logic wake;
  } phwp_row_type;
  logic pclk = 1'b0; // Clock
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0000_0000; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready, pslverr; // APB answer
  logic [7:0] input_data_lines, output_data_lines; // Data pins
  logic peripheral_control_line, module_control_line; // Control pins
  logic wake_line = 1'b0; // Wake pin
  logic wake_irq, irq; // Interrupts
  logic active = 1'b0, stall = 1'b0; // Partner controls
  logic [7:0] byte_in = 8'h00; // Partner byte
  logic [31:0] rd; // Last read word
  logic er; // Last error flag
  int mismatches = 0;
  int compares = 0;
  phwp_row_type rows [8] = '{
    '{PHWP_WAKE_OFF, 32'h8000_0002, 1'b0, 1'b1},
    '{PHWP_MASKW_OFF, 32'h0000_0000, 1'b0, 1'b0},
    '{PHWP_MASKW_OFF, 32'h0000_0002, 1'b0, 1'b1},
    '{PHWP_MASKW_OFF, 32'h0000_03E8, 1'b1, 1'b1},
    '{PHWP_WAKE_OFF, 32'h83E8_0002, 1'b1, 1'b1},
    '{PHWP_WAKE_OFF, 32'h0000_0000, 1'b0, 1'b0},
    '{PHWP_WAKE_OFF, 32'h8000_0004, 1'b0, 1'b0},
    '{8'h20, 32'h8000_0002, 1'b1, 1'b0}};

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  phwp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_data_lines(input_data_lines),
    .peripheral_control_line(peripheral_control_line), .wake_line(wake_line),
    .output_data_lines(output_data_lines), .module_control_line(module_control_line),
    .wake_irq(wake_irq), .irq(irq));

  phwp_peripheral peer (.pclk(pclk), .active(active), .stall(stall), .byte_in(byte_in),
    .module_control_line(module_control_line), .input_data_lines(input_data_lines),
    .peripheral_control_line(peripheral_control_line));

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Bounded wait on the module control pin
  task automatic wait_ctl(input logic v);
    for (int i = 0; i < 500 && module_control_line !== v; i++)
      @(posedge pclk);
    chk(module_control_line, v);
  endtask

  // Bounded wait for an output byte
  task automatic wait_out(input logic [7:0] v);
    for (int i = 0; i < 200 && output_data_lines !== v; i++)
      @(posedge pclk);
    chk(output_data_lines, v);
  endtask

  // Watchdog sized well above the expected run
  initial
  begin
    #900_000;
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(module_control_line, 1'b1);
    // Wake unit and register refusals, one row per write
    byte_in <= 8'h02;
    wake_line <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      chk(er, rows[i].err);
      repeat (6) @(posedge pclk);
      chk(wake_irq, rows[i].wake);
    end
    apb(1'b1, PHWP_WAKE_OFF, 32'h8000_0002);
    wake_line <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(wake_irq, 1'b0);
    apb(1'b1, PHWP_WAKE_OFF, 32'h0000_0000);
    $display("test wake done");
    // Interlocked input with a slow peripheral and zero delay
    apb(1'b1, PHWP_IEN_OFF, 32'h0000_0001);
    byte_in <= 8'hA5;
    stall <= 1'b1;
    active <= 1'b1;
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0001);
    wait_ctl(1'b0);
    wait_ctl(1'b1);
    repeat (50) @(posedge pclk);
    chk(module_control_line, 1'b1);
    apb(1'b0, PHWP_RXD_OFF, 32'h0000_0000);
    chk(rd[7:0], 8'hA5);
    chk(irq, 1'b1);
    stall <= 1'b0;
    wait_ctl(1'b0);
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0000);
    active <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b1, PHWP_STAT_OFF, 32'h0000_001F);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    $display("test handshake done");
    // Interlocked input with one delay unit; peripheral never acks
    byte_in <= 8'h77;
    stall <= 1'b1;
    active <= 1'b1;
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0101);
    wait_ctl(1'b0);
    wait_ctl(1'b1);
    // Busy must outlast most of one unit, then the wait gives up
    repeat (PHWP_UNIT_CYC - 1000) @(posedge pclk);
    chk(module_control_line, 1'b1);
    for (int i = 0; i < 2000 && module_control_line !== 1'b0; i++)
      @(posedge pclk);
    chk(module_control_line, 1'b0);
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0000);
    active <= 1'b0;
    stall <= 1'b0;
    apb(1'b0, PHWP_STAT_OFF, 32'h0000_0000);
    chk(rd[PHWP_EV_TMO], 1'b1);
    $display("test timeout done");
    // Strobe input, zero delay
    byte_in <= 8'h5A;
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0002);
    wait_ctl(1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, PHWP_RXD_OFF, 32'h0000_0000);
    chk(rd[7:0], 8'h5A);
    $display("test strobe in done");
    // Strobe output, inverted then plain polarity
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0007);
    apb(1'b1, PHWP_TXD_OFF, 32'h0000_003C);
    wait_out(8'hC3);
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0003);
    apb(1'b1, PHWP_TXD_OFF, 32'h0000_003C);
    wait_out(8'h3C);
    wait_ctl(1'b0);
    $display("test strobe out done");
    // Reset in mid-run: strobe input running, wake armed, byte on the pins
    apb(1'b1, PHWP_WAKE_OFF, 32'h8000_0002);
    byte_in <= 8'h02;
    wake_line <= 1'b1;
    apb(1'b1, PHWP_CTRL_OFF, 32'h0000_0002);
    repeat (6) @(posedge pclk);
    chk(wake_irq, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    // Data lines, control, wake, irq, ready at their reset levels
    chk({output_data_lines, module_control_line, wake_irq, irq, pready}, 12'h008);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(module_control_line, 1'b1);
    apb(1'b0, PHWP_CTRL_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    repeat (6) @(posedge pclk);
    chk(wake_irq, 1'b0);
    $display("test reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
